// [verilog/ddi_mem_end.sv]
// DRAM end of the link: command decode, burst engines, DDR data paths,
// a small storage array and per-bank refresh row counters.
// Assumes the controller end keeps command spacing and drives the timing signals.
`timescale 1ns/1ps

// Summary of operation
// - Commands captured on input timing rising edge.
// - Chip select high ignores new commands only.
// - Write enable, refresh select, select form command.
// - Address carries location, or mode at load.
// - Top address bit ignored in wide configuration.
// - Bursts of two, four or eight words.
// - Longer bursts ignore upper address bits.
// - Three bank bits pick one of eight.
// - Write words captured on both data edges.
// - Masked write beats are not stored.
// - Read words driven on both output edges.
// - Output timing pair toggles, data edge-aligned.
// - Pair zero low bits, pair one high.
// - Read valid flag aligned with output timing.
// - Separate one-way buses, two words per cycle.
// - Refresh per bank, row generated inside.
// - Controller refreshes every bank within window.
// - Only defined encodings and sequences allowed.
// - Select, write enable, refresh select encoding.
// - Mode load only idle, low eighteen bits.
// - Used address width follows burst length.
// - Six cycles wait after mode load.
module ddi_mem_end #(
    parameter int DW = ddi_pkg::DDI_DW,
    parameter int RD_LAT = ddi_pkg::DDI_RD_LAT,
    parameter int WR_LAT = ddi_pkg::DDI_WR_LAT,
    parameter int LOC_W = 2
) (
    // Link
    ddi_link_if.mem_side link,
    // Control from the user side, asynchronous to the link
    input wire logic resetn,
    input wire logic clk_en,
    // Status
    output logic [ddi_pkg::DDI_MODE_W-1:0] mode_setting,
    output logic [ddi_pkg::DDI_ADDR_W-1:0] access_addr,
    output logic refresh_strobe,
    output logic [ddi_pkg::DDI_BANK_W-1:0] refresh_bank,
    output logic [ddi_pkg::DDI_ROW_W-1:0] refresh_row
);
    localparam int TOP_BASE = (DW == 9) ? ddi_pkg::DDI_ADDR_TOP_X9
                                        : ddi_pkg::DDI_ADDR_TOP_X18;
    localparam int BASE_W = ddi_pkg::DDI_BANK_W + LOC_W;
    localparam int SLOT_W = BASE_W + 2;
    localparam int DEPTH = 2 ** (SLOT_W + 1);

    // ----------------------------------------------------------------
    // Clocks and synchronisers
    // ----------------------------------------------------------------
    wire link_clk = link.primary_input_timing;
    wire wdata_clk = link.write_data_timing_in;
    logic rst_n_s1;
    logic rst_n_s2;
    logic ce_s1;
    logic ce_s2;

    always_ff @(posedge link_clk)
    begin
        rst_n_s1 <= resetn;
        rst_n_s2 <= rst_n_s1;
        ce_s1 <= clk_en;
        ce_s2 <= ce_s1;
    end

    wire run = rst_n_s2 && ce_s2;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    // Decoded straight from the pins so the capturing flops sit on the
    // rising edge itself; a high select blanks all four strobes only.
    wire sel = !link.cs_n;
    wire is_mode = sel && !link.we_n && !link.refresh_sel_n;
    wire is_rd = sel && link.we_n && link.refresh_sel_n;
    wire is_wr = sel && !link.we_n && link.refresh_sel_n;
    wire is_ref = sel && link.we_n && !link.refresh_sel_n;

    wire [1:0] bsz = mode_setting[ddi_pkg::DDI_BSZ_LSB +: ddi_pkg::DDI_BSZ_W];
    // Reserved burst code is treated as the longest burst
    wire [1:0] bsz_eff = (bsz == 2'h3) ? 2'h2 : bsz;
    wire [2:0] pairs = (bsz_eff == ddi_pkg::DDI_BSZ_2) ? 3'h1 :
                       (bsz_eff == ddi_pkg::DDI_BSZ_4) ? 3'h2 : 3'h4;
    wire [4:0] used_top = 5'(TOP_BASE) - {3'h0, bsz_eff};
    logic [ddi_pkg::DDI_ADDR_W-1:0] addr_used;

    genvar gi;
    generate
        for (gi = 0; gi < ddi_pkg::DDI_ADDR_W; gi++)
        begin : g_addr
            // Bits above the used width are dropped, which covers the
            // reserved top bit and the burst don't-care bits
            assign addr_used[gi] = link.addr[gi] && (5'(gi) <= used_top);
        end
    endgenerate

    wire [BASE_W-1:0] loc_base = {link.bank, addr_used[LOC_W-1:0]};

    // ----------------------------------------------------------------
    // Mode and access registers
    // ----------------------------------------------------------------
    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            mode_setting <= ddi_pkg::DDI_MODE_RST;
            access_addr <= '0;
        end
        else if (ce_s2)
        begin
            if (is_mode)
                mode_setting <= link.addr[ddi_pkg::DDI_MODE_W-1:0];
            if (is_rd || is_wr)
                access_addr <= addr_used;
        end
    end

    // ----------------------------------------------------------------
    // Burst engines
    // ----------------------------------------------------------------
    // One slot per link cycle, each slot a pair of words. A new command
    // reloads the engine; the controller spaces commands by the burst.
    logic [2:0] rd_left;
    logic [2:0] wr_left;
    logic [1:0] rd_pair;
    logic [1:0] wr_pair;
    logic [BASE_W-1:0] rd_base;
    logic [BASE_W-1:0] wr_base;

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            rd_left <= 3'h0;
            rd_pair <= 2'h0;
            rd_base <= '0;
        end
        else if (ce_s2)
        begin
            if (is_rd)
            begin
                rd_left <= pairs;
                rd_pair <= 2'h0;
                rd_base <= loc_base;
            end
            else if (rd_left != 3'h0)
            begin
                rd_left <= rd_left - 3'h1;
                rd_pair <= rd_pair + 2'h1;
            end
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            wr_left <= 3'h0;
            wr_pair <= 2'h0;
            wr_base <= '0;
        end
        else if (ce_s2)
        begin
            if (is_wr)
            begin
                wr_left <= pairs;
                wr_pair <= 2'h0;
                wr_base <= loc_base;
            end
            else if (wr_left != 3'h0)
            begin
                wr_left <= wr_left - 3'h1;
                wr_pair <= wr_pair + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Latency lines
    // ----------------------------------------------------------------
    logic [RD_LAT-2:0] rd_v;
    logic [RD_LAT-2:0][SLOT_W-1:0] rd_i;
    // Two stages past the latency: the write words need two crossing flops
    logic [WR_LAT+1:0] wr_v;
    logic [WR_LAT+1:0][SLOT_W-1:0] wr_i;

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            rd_v <= '0;
            wr_v <= '0;
        end
        else if (ce_s2)
        begin
            rd_v <= {rd_v[RD_LAT-3:0], rd_left != 3'h0};
            wr_v <= {wr_v[WR_LAT:0], wr_left != 3'h0};
        end
    end

    always_ff @(posedge link_clk)
    begin
        if (ce_s2)
        begin
            rd_i <= {rd_i[RD_LAT-3:0], {rd_base, rd_pair}};
            wr_i <= {wr_i[WR_LAT:0], {wr_base, wr_pair}};
        end
    end

    // ----------------------------------------------------------------
    // Write data capture
    // ----------------------------------------------------------------
    // Captured on both edges of the write data timing signal, then moved
    // over two link-clock flops; the words are stable for a full cycle.
    logic [DW-1:0] cap_rise_d;
    logic [DW-1:0] cap_fall_d;
    logic cap_rise_m;
    logic cap_fall_m;
    logic [2*DW+1:0] wr_s1;
    logic [2*DW+1:0] wr_s2;

    always_ff @(posedge wdata_clk)
    begin
        cap_rise_d <= link.wdata;
        cap_rise_m <= link.write_byte_mask;
    end

    always_ff @(negedge wdata_clk)
    begin
        cap_fall_d <= link.wdata;
        cap_fall_m <= link.write_byte_mask;
    end

    always_ff @(posedge link_clk)
    begin
        if (ce_s2)
        begin
            wr_s1 <= {cap_fall_m, cap_fall_d, cap_rise_m, cap_rise_d};
            wr_s2 <= wr_s1;
        end
    end

    wire [DW-1:0] w_rise = wr_s2[DW-1:0];
    wire w_rise_m = wr_s2[DW];
    wire [DW-1:0] w_fall = wr_s2[2*DW:DW+1];
    wire w_fall_m = wr_s2[2*DW+1];
    wire wr_commit = run && wr_v[WR_LAT+1];

    // ----------------------------------------------------------------
    // Storage and read data
    // ----------------------------------------------------------------
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] q_rise;
    logic [DW-1:0] q_fall;

    always_ff @(posedge link_clk)
    begin
        if (wr_commit && !w_rise_m)
            mem[{wr_i[WR_LAT+1], 1'b0}] <= w_rise;
        if (wr_commit && !w_fall_m)
            mem[{wr_i[WR_LAT+1], 1'b1}] <= w_fall;
    end

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            q_rise <= '0;
            q_fall <= '0;
            link.read_valid_flag <= 1'b0;
        end
        else if (ce_s2)
        begin
            q_rise <= mem[{rd_i[RD_LAT-2], 1'b0}];
            q_fall <= mem[{rd_i[RD_LAT-2], 1'b1}];
            link.read_valid_flag <= rd_v[RD_LAT-2];
        end
    end

    // DDR output mux on the link clock: the first word of the pair goes
    // out in the high phase. Both timing pairs follow the same clock, so
    // each stays aligned with its half of the bus.
    assign link.rdata = link_clk ? q_rise : q_fall;
    assign link.read_data_timing_out = {2{link_clk}};
    assign link.read_data_timing_out_n = {2{!link_clk}};

    // ----------------------------------------------------------------
    // Per-bank refresh
    // ----------------------------------------------------------------
    logic [ddi_pkg::DDI_BANKS-1:0][ddi_pkg::DDI_ROW_W-1:0] row_ctr;

    always_ff @(posedge link_clk)
    begin
        if (!rst_n_s2)
        begin
            row_ctr <= '0;
            refresh_strobe <= 1'b0;
            refresh_bank <= '0;
            refresh_row <= '0;
        end
        else if (ce_s2)
        begin
            refresh_strobe <= is_ref;
            if (is_ref)
            begin
                row_ctr[link.bank] <= row_ctr[link.bank] + 13'h0001;
                refresh_bank <= link.bank;
                refresh_row <= row_ctr[link.bank];
            end
        end
    end
endmodule

// [verilog/ddi_pkg.sv]
// Shared constants and types for both ends of the DDR separate-I/O DRAM link.
// Assumes both ends and the link interface are compiled after this package.
package ddi_pkg;
    // ----------------------------------------------------------------
    // Link geometry
    // ----------------------------------------------------------------
    localparam int DDI_ADDR_W = 21;
    localparam int DDI_BANK_W = 3;
    localparam int DDI_BANKS = 8;
    localparam int DDI_DW = 18;
    localparam int DDI_ROW_W = 13;
    // ----------------------------------------------------------------
    // Mode setting layout
    // ----------------------------------------------------------------
    localparam int DDI_MODE_W = 18;
    localparam logic [17:0] DDI_MODE_RST = 18'h00000;
    localparam int DDI_BSZ_LSB = 0;
    localparam int DDI_BSZ_W = 2;
    localparam logic [1:0] DDI_BSZ_2 = 2'h0;
    localparam logic [1:0] DDI_BSZ_4 = 2'h1;
    // Highest used address bit at a burst of two words
    localparam int DDI_ADDR_TOP_X18 = 19;
    localparam int DDI_ADDR_TOP_X9 = 20;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int DDI_RD_LAT = 4;
    localparam int DDI_WR_LAT = 4;
    localparam int DDI_MODE_GAP = 6;
    localparam int DDI_DRAIN_PAD = 8;
    localparam int DDI_HALF_DIV = 4;
    localparam int DDI_CLK_PERIOD_NS = 5;
    localparam int DDI_REF_WINDOW_MS = 32;
    localparam int DDI_REF_PER_BANK = 8192;
    localparam int DDI_REF_INT_NS =
        DDI_REF_WINDOW_MS * 1000000 / (DDI_REF_PER_BANK * DDI_BANKS);
    localparam int DDI_REF_INT_CYC = DDI_REF_INT_NS / DDI_CLK_PERIOD_NS;
    // ----------------------------------------------------------------
    // Controller request kinds
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DDI_OP_READ,
        DDI_OP_WRITE,
        DDI_OP_MODE,
        DDI_OP_REFRESH
    } ddi_op_t;
endpackage

// [verilog/ddi_link_if.sv]
// Pin-level link between the memory controller end and the DRAM end.
// Assumes the controller end makes both input timing signals.
`timescale 1ns/1ps
interface ddi_link_if #(
    parameter int DW = ddi_pkg::DDI_DW
);
    logic primary_input_timing;
    logic write_data_timing_in;
    logic cs_n;
    logic we_n;
    logic refresh_sel_n;
    logic [ddi_pkg::DDI_ADDR_W-1:0] addr;
    logic [ddi_pkg::DDI_BANK_W-1:0] bank;
    logic [DW-1:0] wdata;
    logic write_byte_mask;
    logic [DW-1:0] rdata;
    logic [1:0] read_data_timing_out;
    logic [1:0] read_data_timing_out_n;
    logic read_valid_flag;

    modport mem_side (
        input primary_input_timing, write_data_timing_in, cs_n, we_n, refresh_sel_n,
        input addr, bank, wdata, write_byte_mask,
        output rdata, read_data_timing_out, read_data_timing_out_n, read_valid_flag
    );
    modport ctrl_side (
        output primary_input_timing, write_data_timing_in, cs_n, we_n, refresh_sel_n,
        output addr, bank, wdata, write_byte_mask,
        input rdata, read_data_timing_out, read_data_timing_out_n, read_valid_flag
    );
endinterface

// [verilog/ddi_ctrl_end.sv]
// Controller end of the link: clock divider, command issue with spacing,
// refresh timer, DDR write data launch and read data capture.
// Assumes one request interface on ref_clk and a DRAM end on the link.
`timescale 1ns/1ps
module ddi_ctrl_end #(
    parameter int DW = ddi_pkg::DDI_DW,
    parameter int RD_LAT = ddi_pkg::DDI_RD_LAT,
    parameter int WR_LAT = ddi_pkg::DDI_WR_LAT,
    parameter int HALF = ddi_pkg::DDI_HALF_DIV
) (
    // Link
    ddi_link_if.ctrl_side link,
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // Requests
    input wire logic req_valid,
    output logic req_ready,
    input wire ddi_pkg::ddi_op_t req_op,
    input wire logic [ddi_pkg::DDI_BANK_W-1:0] req_bank,
    input wire logic [ddi_pkg::DDI_ADDR_W-1:0] req_addr,
    // Write data
    output logic wr_pull,
    input wire logic [DW-1:0] wr_data,
    input wire logic wr_mask,
    // Read data and status
    output logic rd_valid,
    output logic [DW-1:0] rd_data,
    output logic refresh_pending
);
    localparam int CW = $clog2(2 * HALF);
    localparam int SCH_W = WR_LAT + 8;
    localparam int RTW = $clog2(ddi_pkg::DDI_REF_INT_CYC);

    // ----------------------------------------------------------------
    // Link clock divider
    // ----------------------------------------------------------------
    // Write data timing lags by a quarter period so its edges land in
    // the middle of each data word.
    logic [CW-1:0] phase;
    wire rise_now = clk_en && phase == CW'(2 * HALF - 1);
    wire fall_now = clk_en && phase == CW'(HALF - 1);
    wire [CW-1:0] next_phase = rise_now ? '0 : phase + CW'(1);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            phase <= '0;
            link.primary_input_timing <= 1'b0;
            link.write_data_timing_in <= 1'b0;
        end
        else if (clk_en)
        begin
            phase <= next_phase;
            link.primary_input_timing <= next_phase < CW'(HALF);
            link.write_data_timing_in <= next_phase >= CW'(HALF / 2) &&
                                         next_phase < CW'(HALF / 2 + HALF);
        end
    end

    // ----------------------------------------------------------------
    // Issue decision
    // ----------------------------------------------------------------
    logic [3:0] gap;
    logic [7:0] drain;
    logic [1:0] bsz;
    logic ref_due;
    logic [RTW-1:0] ref_timer;
    logic [ddi_pkg::DDI_BANK_W-1:0] ref_bank;
    logic [SCH_W-1:0] sched;
    logic pair_on;

    wire [2:0] pairs = (bsz == ddi_pkg::DDI_BSZ_2) ? 3'h1 :
                       (bsz == ddi_pkg::DDI_BSZ_4) ? 3'h2 : 3'h4;
    wire can_cmd = fall_now && gap == 4'h0;
    wire do_ref = can_cmd && ref_due;
    wire mode_ok = req_op != ddi_pkg::DDI_OP_MODE || drain == 8'h00;
    assign req_ready = resetn && can_cmd && !ref_due && mode_ok;
    wire take = req_valid && req_ready;
    wire rd_go = take && req_op == ddi_pkg::DDI_OP_READ;
    wire wr_go = take && req_op == ddi_pkg::DDI_OP_WRITE;
    wire md_go = take && req_op == ddi_pkg::DDI_OP_MODE;
    wire rf_go = do_ref || (take && req_op == ddi_pkg::DDI_OP_REFRESH);
    wire [SCH_W-1:0] burst_ones = ((SCH_W'(1) << pairs) - SCH_W'(1)) << WR_LAT;
    wire ref_wrap = clk_en && ref_timer == RTW'(ddi_pkg::DDI_REF_INT_CYC - 1);
    assign refresh_pending = ref_due;

    // ----------------------------------------------------------------
    // Command pins
    // ----------------------------------------------------------------
    // Launched on the falling link edge so the DRAM end samples them in
    // the middle of the cycle; only the four legal encodings are made.
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            link.cs_n <= 1'b1;
            link.we_n <= 1'b1;
            link.refresh_sel_n <= 1'b1;
            link.addr <= '0;
            link.bank <= '0;
        end
        else if (fall_now)
        begin
            link.cs_n <= !(do_ref || take);
            link.we_n <= !(wr_go || md_go);
            link.refresh_sel_n <= !(md_go || rf_go);
            link.addr <= take ? req_addr : '0;
            link.bank <= do_ref ? ref_bank : (take ? req_bank : '0);
        end
    end

    // ----------------------------------------------------------------
    // Spacing, mode mirror and refresh timer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            gap <= 4'h0;
            drain <= 8'h00;
            bsz <= ddi_pkg::DDI_MODE_RST[ddi_pkg::DDI_BSZ_LSB +: ddi_pkg::DDI_BSZ_W];
        end
        else if (fall_now && (rd_go || wr_go))
        begin
            gap <= {1'b0, pairs};
            drain <= 8'(RD_LAT + WR_LAT + ddi_pkg::DDI_DRAIN_PAD);
        end
        else if (fall_now && md_go)
        begin
            gap <= 4'(ddi_pkg::DDI_MODE_GAP);
            bsz <= req_addr[ddi_pkg::DDI_BSZ_LSB +: ddi_pkg::DDI_BSZ_W];
        end
        else if (fall_now && rf_go)
            gap <= 4'h1;
        else if (rise_now)
        begin
            gap <= (gap == 4'h0) ? 4'h0 : gap - 4'h1;
            drain <= (drain == 8'h00) ? 8'h00 : drain - 8'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            ref_timer <= '0;
            ref_due <= 1'b0;
            ref_bank <= '0;
        end
        else if (clk_en)
        begin
            ref_timer <= ref_wrap ? '0 : ref_timer + RTW'(1);
            // A new interval beats the clear of the previous one
            ref_due <= ref_wrap || (ref_due && !do_ref);
            if (do_ref)
                ref_bank <= ref_bank + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // Write data launch
    // ----------------------------------------------------------------
    assign wr_pull = (rise_now && sched[0]) || (fall_now && pair_on);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sched <= '0;
            pair_on <= 1'b0;
            link.wdata <= '0;
            link.write_byte_mask <= 1'b1;
        end
        else if (fall_now)
        begin
            sched <= wr_go ? (sched | burst_ones) : sched;
            link.wdata <= pair_on ? wr_data : '0;
            link.write_byte_mask <= pair_on ? wr_mask : 1'b1;
        end
        else if (rise_now)
        begin
            sched <= sched >> 1;
            pair_on <= sched[0];
            link.wdata <= sched[0] ? wr_data : '0;
            link.write_byte_mask <= sched[0] ? wr_mask : 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Read data capture
    // ----------------------------------------------------------------
    // Two flops, then each word is taken late in its half period, where
    // the second stage is known to be settled.
    logic [DW-1:0] q_s1;
    logic [DW-1:0] q_s2;
    logic v_s1;
    logic v_s2;
    wire take_pt = phase == CW'(HALF) || phase == '0;

    always_ff @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            q_s1 <= link.rdata;
            q_s2 <= q_s1;
            v_s1 <= link.read_valid_flag;
            v_s2 <= v_s1;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rd_valid <= 1'b0;
            rd_data <= '0;
        end
        else
        begin
            rd_valid <= clk_en && take_pt && v_s2;
            if (clk_en && take_pt && v_s2)
                rd_data <= q_s2;
        end
    end
endmodule

// [bench/ddi_assertions.sv]
// Link checks between the controller end and the DRAM end.
// Assumes resetn is the DRAM end's reset and the link clock runs after it.
`timescale 1ns/1ps
module ddi_assertions (
    // Link
    input wire logic primary_input_timing,
    input wire logic cs_n,
    input wire logic we_n,
    input wire logic refresh_sel_n,
    input wire logic [20:0] addr,
    input wire logic [2:0] bank,
    input wire logic [1:0] read_data_timing_out,
    input wire logic [1:0] read_data_timing_out_n,
    input wire logic read_valid_flag,
    // Reset
    input wire logic resetn
);
    wire rd_cmd = !cs_n && we_n && refresh_sel_n;
    wire md_cmd = !cs_n && !we_n && !refresh_sel_n;
    default clocking cb @(posedge primary_input_timing);
    endclocking
    default disable iff (!resetn);
    // ------------------------------------------------
    // Valid is seen one edge after the edge loading it
    // ------------------------------------------------
    sequence s_quiet; !rd_cmd [*8]; endsequence
    property p_lat; rd_cmd |-> ##5 read_valid_flag; endproperty
    property p_rise; $rose(read_valid_flag) |-> $past(rd_cmd, 5); endproperty
    property p_fall; $fell(read_valid_flag) |-> !$past(rd_cmd, 5); endproperty
    property p_quiet; s_quiet |=> !read_valid_flag; endproperty
    property p_other; !cs_n && !rd_cmd |-> ##5 !read_valid_flag; endproperty
    property p_qk; read_data_timing_out == 2'h0 && read_data_timing_out_n == 2'h3; endproperty
    property p_idle; cs_n |-> addr == 21'h0 && bank == 3'h0; endproperty
    property p_gap; md_cmd |=> cs_n [*5]; endproperty
    a_lat: assert property (p_lat) else $error("late valid");
    a_rise: assert property (p_rise) else $error("stray valid");
    a_fall: assert property (p_fall) else $error("short valid");
    a_quiet: assert property (p_quiet) else $error("valid when idle");
    a_other: assert property (p_other) else $error("valid after non-read");
    a_qk: assert property (p_qk) else $error("timing pair off");
    a_idle: assert property (p_idle) else $error("idle pins set");
    a_gap: assert property (p_gap) else $error("mode gap short");
endmodule

// [bench/tb_top.sv]
// Bench joining the controller end and the DRAM end over the link.
// Assumes the controller end divides the link clock from ref_clk.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic mem_resetn = 1'b0;
    logic req_valid = 1'b0;
    ddi_pkg::ddi_op_t req_op = ddi_pkg::DDI_OP_READ;
    logic [2:0] req_bank = 3'h0;
    logic [20:0] req_addr = 21'h0;
    logic [17:0] wq [20];
    logic wm [20];
    logic [17:0] rq [16];
    logic [17:0] rd_data, mode_setting;
    logic [20:0] access_addr;
    logic req_ready, wr_pull, rd_valid, refresh_strobe;
    logic [2:0] refresh_bank;
    logic [12:0] refresh_row;
    int rows [8];
    int wi = 0, ri = 0, nref = 0, miscompares = 0, total_checks = 0;
    ddi_link_if link ();
    ddi_ctrl_end u_ddi_ctrl_end (.link(link.ctrl_side), .ref_clk(ref_clk), .resetn(resetn),
        .clk_en(1'b1), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_bank(req_bank), .req_addr(req_addr), .wr_pull(wr_pull), .wr_data(wq[wi]),
        .wr_mask(wm[wi]), .rd_valid(rd_valid), .rd_data(rd_data), .refresh_pending());
    ddi_mem_end u_ddi_mem_end (.link(link.mem_side), .resetn(mem_resetn), .clk_en(1'b1),
        .mode_setting(mode_setting), .access_addr(access_addr),
        .refresh_strobe(refresh_strobe), .refresh_bank(refresh_bank),
        .refresh_row(refresh_row));
    ddi_assertions u_ddi_assertions (.primary_input_timing(link.primary_input_timing),
        .cs_n(link.cs_n), .we_n(link.we_n), .refresh_sel_n(link.refresh_sel_n),
        .addr(link.addr), .bank(link.bank), .read_data_timing_out(link.read_data_timing_out),
        .read_data_timing_out_n(link.read_data_timing_out_n),
        .read_valid_flag(link.read_valid_flag), .resetn(mem_resetn));
    // ----------------------
    // Clock and data capture
    // ----------------------
    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        if (wr_pull) wi <= wi + 1;
        if (rd_valid) rq[ri] <= rd_data;
        if (rd_valid) ri <= ri + 1;
    end
    // Strobe stands one link cycle, so it is looked at mid-cycle
    always @(negedge link.primary_input_timing)
    begin
        if (refresh_strobe)
        begin
            chk(21'(refresh_row), 21'(rows[refresh_bank]));
            rows[refresh_bank]++;
            nref <= nref + 1;
        end
    end
    // -----
    // Tasks
    // -----
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input ddi_pkg::ddi_op_t op, input logic [2:0] b, input logic [20:0] a);
        @(posedge ref_clk);
        req_op <= op;
        req_bank <= b;
        req_addr <= a;
        req_valid <= 1'b1;
        do @(negedge ref_clk); while (req_ready !== 1'b1);
        @(posedge ref_clk);
        req_valid <= 1'b0;
    endtask
    task automatic print_verdict();
        $display("checks=%0d miscompares=%0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // -----
    // Tests
    // -----
    initial
    begin
        for (int i = 0; i < 20; i++)
        begin
            wq[i] = {i[5:0], 12'hA5C};
            wm[i] = (i == 9);
        end
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        // The DRAM end syncs reset on the link clock, which only runs now
        repeat (300) @(posedge ref_clk);
        mem_resetn <= 1'b1;
        repeat (300) @(posedge ref_clk);
        issue(ddi_pkg::DDI_OP_MODE, 3'h0, 21'h1);
        issue(ddi_pkg::DDI_OP_WRITE, 3'h3, 21'h0);
        issue(ddi_pkg::DDI_OP_WRITE, 3'h5, 21'h0);
        issue(ddi_pkg::DDI_OP_WRITE, 3'h3, 21'h180000);
        repeat (600) @(posedge ref_clk);
        chk(access_addr, 21'h0);
        issue(ddi_pkg::DDI_OP_READ, 3'h3, 21'h100000);
        issue(ddi_pkg::DDI_OP_READ, 3'h5, 21'h0);
        wait (ri == 8);
        for (int i = 0; i < 8; i++)
            chk(21'(rq[i]), 21'(i > 3 ? wq[i] : wq[i == 1 ? 1 : i + 8]));
        chk(21'(mode_setting), 21'h1);
        issue(ddi_pkg::DDI_OP_MODE, 3'h0, 21'h2);
        issue(ddi_pkg::DDI_OP_WRITE, 3'h1, 21'h0C0001);
        repeat (600) @(posedge ref_clk);
        chk(access_addr, 21'h1);
        issue(ddi_pkg::DDI_OP_READ, 3'h1, 21'h1);
        wait (ri == 16);
        for (int i = 8; i < 16; i++)
            chk(21'(rq[i]), 21'(wq[i + 4]));
        chk(21'(mode_setting), 21'h2);
        chk(21'(nref != 0), 21'h1);
        print_verdict();
    end
    initial
    begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule
